// file: hdl/ucps_dbg_decode.sv
`timescale 1ns/1ps
`default_nettype none
module ucps_dbg_decode (
   input wire logic [3:0] code,
   output logic [ucps_pkg::UCPS_DBG_PINS-1:0] onehot
);
   import ucps_pkg::*;
   // code 0xF..0x5 maps to index 10..0, others select nothing
   genvar i;
   generate
      for (i = 0; i < UCPS_DBG_PINS; i++) begin : g_dec
         assign onehot[i] = (code == 4'(UCPS_DBG_CODE_MIN + 4'(i)));
      end
   endgenerate
endmodule : ucps_dbg_decode
`default_nettype wire

// file: hdl/ucps_pkg.sv
package ucps_pkg;
   // register byte offsets
   localparam logic [11:0] UCPS_MCU_CONFIG_OFS = 12'h000;
   localparam logic [11:0] UCPS_IO_FUNCTION_CONFIG_OFS = 12'h004;
   localparam int UCPS_ADDR_W = 12;
   // mcu_config fields
   localparam int UCPS_XTAL_SEL_BIT = 8;
   localparam int UCPS_DBG_PROT_BIT = 4;
   localparam int UCPS_BOOT_MAP_BIT = 3;
   // io_function_config fields
   localparam int UCPS_XTAL_PIN_BIT = 9;
   localparam int UCPS_RST_PIN_BIT = 8;
   localparam int UCPS_SWCLK_LSB = 4;
   localparam int UCPS_SWDIO_LSB = 0;
   // reset values
   localparam logic UCPS_XTAL_SEL_RST = 1'b1;
   localparam logic UCPS_DBG_PROT_RST = 1'b1;
   localparam logic UCPS_BOOT_MAP_RST = 1'b1;
   localparam logic UCPS_XTAL_PIN_RST = 1'b1;
   localparam logic UCPS_RST_PIN_RST = 1'b1;
   localparam logic [3:0] UCPS_SWCLK_RST = 4'hF;
   localparam logic [3:0] UCPS_SWDIO_RST = 4'hF;
   // flash commands that drop debug protection
   localparam logic [3:0] UCPS_FCMD_UNPROT_A = 4'h6;
   localparam logic [3:0] UCPS_FCMD_UNPROT_B = 4'h7;
   // lowest code that maps a debug pin
   localparam logic [3:0] UCPS_DBG_CODE_MIN = 4'h5;
   localparam int UCPS_DBG_PINS = 11;
endpackage : ucps_pkg

// file: hdl/ucps_top.sv
// Function
// - Crystal select bit 8 of mcu_config picks the fast crystal when set and the 32.768 kHz one when clear, reset one.
// - Boot mapping bit 3 boots main code when one and the in-system-programming code when zero, reset one.
// - Bit 9 of io_function_config gives P1.0/P1.1 to GPIO when zero and to the crystal when one.
// - Bit 8 of io_function_config zero puts external reset on P14 taking its GPIO away; one disables external reset.
// - Bits 7:4 route the debug clock to P13,P20,P01,P26,P23,P03,P05,P16,P07,P30,P22 for 0xF down to 0x5, taking GPIO away.
// - Any other debug clock code connects the debug clock to no pin.
// - Bits 3:0 route debug data to P12,P00,P15,P25,P24,P02,P04,P17,P06,P27,P21 for 0xF down to 0x5, taking GPIO away.
// - Any other debug data code connects debug data to no pin.
// - mcu_config sits at 0x000 and io_function_config at 0x004, both read and write.
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ucps_top (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [ucps_pkg::UCPS_ADDR_W-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic flash_cmd_valid,
   input wire logic [3:0] flash_function_command,
   output logic crystal_source_select,
   output logic debug_protect,
   output logic boot_mapping_select,
   output logic crystal_pin_assign,
   output logic ext_reset_enable,
   output logic [15:0] gpio_release,
   output logic [ucps_pkg::UCPS_DBG_PINS-1:0] swclk_pin_sel,
   output logic [ucps_pkg::UCPS_DBG_PINS-1:0] swdio_pin_sel,
   output logic swclk_enable,
   output logic swdio_enable
);
   import ucps_pkg::*;

   // -----------------------------------------------------------------
   // register state
   // -----------------------------------------------------------------
   logic xtal_sel_r;
   logic dbg_prot_r;
   logic boot_map_r;
   logic xtal_pin_r;
   logic rst_pin_r;
   logic [3:0] swclk_code_r;
   logic [3:0] swdio_code_r;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [UCPS_DBG_PINS-1:0] clk_oh;
   logic [UCPS_DBG_PINS-1:0] dio_oh;
   logic wr_mcu;
   logic wr_io;
   logic unprot_cmd;

   function automatic logic hit(input logic [UCPS_ADDR_W-1:0] a,
                                input logic [UCPS_ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   assign wr_mcu = wr && hit(addr, UCPS_MCU_CONFIG_OFS);
   assign wr_io = wr && hit(addr, UCPS_IO_FUNCTION_CONFIG_OFS);
   assign unprot_cmd = flash_cmd_valid &&
      ((flash_function_command == UCPS_FCMD_UNPROT_A) ||
       (flash_function_command == UCPS_FCMD_UNPROT_B));

   // -----------------------------------------------------------------
   // mcu_config
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         xtal_sel_r <= UCPS_XTAL_SEL_RST;
         boot_map_r <= UCPS_BOOT_MAP_RST;
      end else if (wr_mcu) begin
         xtal_sel_r <= wdata[UCPS_XTAL_SEL_BIT];
         boot_map_r <= wdata[UCPS_BOOT_MAP_BIT];
      end
   end

   // hardware unprotect wins over a software write in the same cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dbg_prot_r <= UCPS_DBG_PROT_RST;
      end else if (unprot_cmd) begin
         dbg_prot_r <= 1'b1;
      end else if (wr_mcu) begin
         dbg_prot_r <= wdata[UCPS_DBG_PROT_BIT];
      end
   end

   // -----------------------------------------------------------------
   // io_function_config
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         xtal_pin_r <= UCPS_XTAL_PIN_RST;
         rst_pin_r <= UCPS_RST_PIN_RST;
         swclk_code_r <= UCPS_SWCLK_RST;
         swdio_code_r <= UCPS_SWDIO_RST;
      end else if (wr_io) begin
         xtal_pin_r <= wdata[UCPS_XTAL_PIN_BIT];
         rst_pin_r <= wdata[UCPS_RST_PIN_BIT];
         swclk_code_r <= wdata[UCPS_SWCLK_LSB +: 4];
         swdio_code_r <= wdata[UCPS_SWDIO_LSB +: 4];
      end
   end

   // -----------------------------------------------------------------
   // read path
   // -----------------------------------------------------------------
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (rd && hit(addr, UCPS_MCU_CONFIG_OFS)) begin
         rdata_nxt[UCPS_XTAL_SEL_BIT] = xtal_sel_r;
         rdata_nxt[UCPS_DBG_PROT_BIT] = dbg_prot_r;
         rdata_nxt[UCPS_BOOT_MAP_BIT] = boot_map_r;
      end else if (rd && hit(addr, UCPS_IO_FUNCTION_CONFIG_OFS)) begin
         rdata_nxt[UCPS_XTAL_PIN_BIT] = xtal_pin_r;
         rdata_nxt[UCPS_RST_PIN_BIT] = rst_pin_r;
         rdata_nxt[UCPS_SWCLK_LSB +: 4] = swclk_code_r;
         rdata_nxt[UCPS_SWDIO_LSB +: 4] = swdio_code_r;
      end
   end

   // unmapped reads and idle cycles return zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end
   assign rdata = rdata_r;

   // -----------------------------------------------------------------
   // pin routing
   // -----------------------------------------------------------------
   ucps_dbg_decode u_clk_dec (
      .code(swclk_code_r),
      .onehot(clk_oh)
   );
   ucps_dbg_decode u_dio_dec (
      .code(swdio_code_r),
      .onehot(dio_oh)
   );

   assign crystal_source_select = xtal_sel_r;
   assign debug_protect = dbg_prot_r;
   assign boot_mapping_select = boot_map_r;
   assign crystal_pin_assign = xtal_pin_r;
   assign ext_reset_enable = ~rst_pin_r;
   // index 0 is code 0x5, index 10 is code 0xF
   assign swclk_pin_sel = clk_oh;
   assign swdio_pin_sel = dio_oh;
   assign swclk_enable = |clk_oh;
   assign swdio_enable = |dio_oh;

   // gpio_release bit order: P10,P11,P14, then bit 3 for any swclk pin and
   // bit 4 for any swdio pin; swclk and swdio selects are ORed into bits 5..15
   // so swclk_pin_sel and swdio_pin_sel keep one bit per pad function taken
   assign gpio_release[0] = xtal_pin_r;
   assign gpio_release[1] = xtal_pin_r;
   assign gpio_release[2] = ~rst_pin_r;
   assign gpio_release[3] = |clk_oh;
   assign gpio_release[4] = |dio_oh;
   assign gpio_release[15:5] = clk_oh | dio_oh;
endmodule : ucps_top
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk, rstn, wr, rd, go, flash_cmd_valid, crystal_source_select;
   logic debug_protect, boot_mapping_select, crystal_pin_assign;
   logic ext_reset_enable, swclk_enable, swdio_enable;
   logic [11:0] addr;
   logic [31:0] wdata, rdata, v;
   logic [3:0] code, flash_function_command, c;
   logic [15:0] gpio_release;
   logic [10:0] swclk_pin_sel, swdio_pin_sel;
   int failures = 0, total_checks = 0, cyc = 0;
   ucps_top DUT (.*);
   ucps_flash_model u_flash (.*);
   // ----
   // helpers
   // ----
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   function automatic logic [10:0] pmap(logic [3:0] k);
      return (k < 4'h5) ? 11'h0 : 11'h1 << (k - 4'h5);
   endfunction : pmap
   task automatic wreg(logic [11:0] a, logic [31:0] d);
      @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
      @(posedge clk) wr <= 1'b0;
      #1;
   endtask : wreg
   task automatic rreg(logic [11:0] a);
      @(posedge clk) {rd, addr} <= {1'b1, a};
      @(posedge clk) rd <= 1'b0;
      #1 v = rdata;
   endtask : rreg
   task automatic end_sim;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   // ----
   // scenarios
   // ----
   task automatic t_reset_unmapped;
      rreg(12'h000); chk("mcu reset", v, 32'h118);
      wreg(12'h008, 32'h0);
      rreg(12'h008); chk("unmapped", v, 32'h0);
      rreg(12'h004); chk("io reset", v, 32'h3FF);
   endtask : t_reset_unmapped
   task automatic t_mcu;
      wreg(12'h000, 32'hFFFF_FFFF);
      rreg(12'h000); chk("mcu rsvd", v, 32'h118);
      wreg(12'h000, 32'h0);
      chk("mcu outs", {crystal_source_select, boot_mapping_select}, 0);
      rreg(12'h000); chk("mcu zero", v, 32'h0);
   endtask : t_mcu
   task automatic t_flash;
      for (int i = 0; i < 16; i++) begin
         wreg(12'h000, 32'h0);
         @(posedge clk) {go, code} <= {1'b1, 4'(i)};
         @(posedge clk) go <= 1'b0;
         @(posedge clk) #1;
         chk("unprotect", debug_protect, (i == 6 || i == 7));
      end
   endtask : t_flash
   task automatic t_pins;
      for (int i = 0; i < 16; i++) begin
         c = 4'(i);
         wreg(12'h004, {22'h0, c[0], c[1], c, ~c});
         chk("xtal pin", crystal_pin_assign, c[0]);
         chk("rst pin", {ext_reset_enable, gpio_release[2]}, {2{~c[1]}});
         chk("swclk", {swclk_enable, swclk_pin_sel}, {c > 4'h4, pmap(c)});
         chk("swdio", {swdio_enable, swdio_pin_sel}, {~c > 4'h4, pmap(~c)});
         rreg(12'h004); chk("io rb", v, {22'h0, c[0], c[1], c, ~c});
      end
   endtask : t_pins
   initial forever #20 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         failures++;
         end_sim;
      end
   end
   initial begin
      {clk, rstn, wr, rd, go, addr, wdata, code} = '0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      t_reset_unmapped;
      t_mcu;
      t_flash;
      t_pins;
      end_sim;
   end
endmodule : tb_top
bind ucps_top ucps_props u_props (.*);
`default_nettype wire

// file: tb/ucps_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module ucps_flash_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic go,
   input wire logic [3:0] code,
   output logic flash_cmd_valid,
   output logic [3:0] flash_function_command
);
   // ----
   // flash controller stand-in
   // ----
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flash_cmd_valid <= 1'b0;
         flash_function_command <= 4'h0;
      end else begin
         flash_cmd_valid <= go;
         // idle code keeps moving, so a stale code cannot pass for valid
         flash_function_command <= go ? code : ~flash_function_command;
      end
   end
endmodule : ucps_flash_model
`default_nettype wire

// file: tb/ucps_props_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ucps_props (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [11:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic flash_cmd_valid,
   input wire logic [3:0] flash_function_command,
   input wire logic crystal_source_select,
   input wire logic debug_protect,
   input wire logic crystal_pin_assign,
   input wire logic ext_reset_enable,
   input wire logic [15:0] gpio_release,
   input wire logic [10:0] swclk_pin_sel,
   input wire logic [10:0] swdio_pin_sel
);
   // ----
   // port relations
   // ----
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   chk_rd_idle: assert property (
      !rd |=> rdata == 32'h0) else $error("rdata not idle");
   chk_flash_unprot: assert property (
      flash_cmd_valid && flash_function_command[3:1] == 3'h3 |=>
      debug_protect) else $error("flash command kept protection");
   chk_xsel_write: assert property (
      wr && addr == 12'h000 |=> crystal_source_select == $past(wdata[8]))
      else $error("crystal select not written");
   chk_xtal_pins: assert property (
      gpio_release[1:0] == {2{crystal_pin_assign}})
      else $error("crystal pins release wrong");
   chk_reset_pin: assert property (
      wr && addr == 12'h004 |=> ext_reset_enable == !$past(wdata[8]) &&
      gpio_release[2] == ext_reset_enable) else $error("reset pin wrong");
   chk_swclk_map: assert property (
      wr && addr == 12'h004 |=> swclk_pin_sel ==
      ((16'h1 << $past(wdata[7:4])) >> 5)) else $error("swclk map wrong");
   chk_swdio_map: assert property (
      wr && addr == 12'h004 |=> swdio_pin_sel ==
      ((16'h1 << $past(wdata[3:0])) >> 5)) else $error("swdio map wrong");
   chk_gpio_take: assert property (
      gpio_release[15:3] == {swclk_pin_sel | swdio_pin_sel,
      |swdio_pin_sel, |swclk_pin_sel}) else $error("gpio release wrong");
   chk_rsvd_zero: assert property (
      rd && addr == 12'h000 |=> rdata[31:9] == 23'h0 && rdata[7:5] == 3'h0
      && rdata[2:0] == 3'h0) else $error("reserved bits set");
endmodule : ucps_props
`default_nettype wire
